// *** hw/spi_eeprom_command_front_end.sv ***
// serial slave front end: shifting, pause, decode and status register
`timescale 1ns/100ps
`include "spi_eeprom_cfg.svh"

module spi_eeprom_command_front_end #(
   parameter int unsigned WRITE_CYCLE_CYCLES = `SPI_WRITE_CYCLE_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic supply_ok,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic hold_n,
   input wire logic wp_n,
   input wire logic ext_write_busy,
   input wire logic ext_write_done,
   output logic miso,
   output logic miso_oe_n,
   output logic [7:0] status_byte_r,
   output logic standby
);

   localparam logic [`SPI_WC_CNT_W-1:0] WC_LOAD = `SPI_WC_CNT_W'(WRITE_CYCLE_CYCLES - 1);

   // ==========================================================
   // link domain: input shifting and instruction decode
   spi_eeprom_pkg::link_state_t state_r;
   spi_eeprom_pkg::link_state_t state_nxt;
   logic [2:0] bit_cnt_r;
   logic [7:0] in_sh_r;
   logic pause_r;
   logic [7:0] st_s1_r;
   logic [7:0] st_s2_r;
   logic [`EV_NUM-1:0] ev_tgl_r;
   logic [7:0] status_write_cmd_data_r;
   logic [7:0] out_sh_r;
   logic drive_r;

   wire [7:0] in_byte = {in_sh_r[6:0], mosi};
   wire byte_end = bit_cnt_r == 3'h7;
   wire link_busy = st_s2_r[`SR_BUSY_BIT];
   wire op_set = in_byte == `OP_SET_LATCH;
   wire op_clear = in_byte == `OP_CLEAR_LATCH;
   wire op_sread = in_byte == `OP_STATUS_READ;
   wire op_swrite = in_byte == `OP_STATUS_WRITE;
   wire op_aread = in_byte == `OP_ARRAY_READ;
   wire op_awrite = in_byte == `OP_ARRAY_WRITE;
   wire op_ext = (in_byte == `OP_IDENT_READ) || (in_byte == `OP_IDENT_WRITE)
      || (in_byte == `OP_UNIQUE_READ);
   wire cmd_end = (state_r == spi_eeprom_pkg::LS_CMD) && byte_end;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         spi_eeprom_pkg::LS_CMD: begin
            if (byte_end) begin
               if (op_set || op_clear) begin
                  state_nxt = spi_eeprom_pkg::LS_WAIT;
               end else if (op_sread) begin
                  state_nxt = spi_eeprom_pkg::LS_STATUS;
               end else if (op_swrite) begin
                  state_nxt = spi_eeprom_pkg::LS_STATUS_WRITE_CMD;
               end else if (op_aread) begin
                  // refused while a write cycle runs
                  state_nxt = link_busy ? spi_eeprom_pkg::LS_WAIT
                     : spi_eeprom_pkg::LS_HANDOFF;
               end else if (op_awrite || op_ext) begin
                  state_nxt = spi_eeprom_pkg::LS_HANDOFF;
               end else begin
                  state_nxt = spi_eeprom_pkg::LS_WAIT;
               end
            end
         end
         spi_eeprom_pkg::LS_STATUS_WRITE_CMD: begin
            if (byte_end) begin
               state_nxt = spi_eeprom_pkg::LS_STATUS_WRITE_CMD_DONE;
            end
         end
         spi_eeprom_pkg::LS_STATUS_WRITE_CMD_DONE: begin
            state_nxt = spi_eeprom_pkg::LS_WAIT;
         end
         default: begin
            state_nxt = state_r;
         end
      endcase
   end

   // deselect clears the decode state, bit count and input shift, pause included
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         state_r <= spi_eeprom_pkg::LS_CMD;
         bit_cnt_r <= 3'h0;
         in_sh_r <= 8'h00;
         pause_r <= 1'b0;
      end else begin
         pause_r <= ~hold_n;
         if (hold_n) begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            in_sh_r <= in_byte;
            state_r <= state_nxt;
         end
      end
   end

   // status byte as flags into the link domain; each bit is an
   // independent level, so per-bit synchronising is enough
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         st_s1_r <= 8'h00;
         st_s2_r <= 8'h00;
      end else begin
         st_s1_r <= status_byte_r;
         st_s2_r <= st_s1_r;
      end
   end

   // events toggle here and survive deselect; supply loss clears them
   always_ff @(posedge sclk or negedge supply_ok) begin
      if (!supply_ok) begin
         ev_tgl_r <= '0;
         status_write_cmd_data_r <= 8'h00;
      end else if (!cs_n && hold_n) begin
         if (cmd_end && op_set) begin
            ev_tgl_r[`EV_SET] <= ~ev_tgl_r[`EV_SET];
         end
         if (cmd_end && op_clear) begin
            ev_tgl_r[`EV_CLEAR] <= ~ev_tgl_r[`EV_CLEAR];
         end
         if ((state_r == spi_eeprom_pkg::LS_STATUS_WRITE_CMD) && byte_end) begin
            ev_tgl_r[`EV_STATUS_WRITE_CMD] <= ~ev_tgl_r[`EV_STATUS_WRITE_CMD];
            status_write_cmd_data_r <= in_byte;
         end
         // a clock beyond the data byte cancels the status write
         if (state_r == spi_eeprom_pkg::LS_STATUS_WRITE_CMD_DONE) begin
            ev_tgl_r[`EV_ABORT] <= ~ev_tgl_r[`EV_ABORT];
         end
      end
   end

   // ==========================================================
   // link domain: output shifting on the falling edge
   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         out_sh_r <= 8'h00;
         drive_r <= 1'b0;
      end else if (hold_n && !pause_r && (state_r == spi_eeprom_pkg::LS_STATUS)) begin
         drive_r <= 1'b1;
         if (bit_cnt_r == 3'h0) begin
            out_sh_r <= st_s2_r;
         end else begin
            out_sh_r <= {out_sh_r[6:0], 1'b0};
         end
      end
   end

   // pause follows the pin in the low phase and holds through the high
   // phase, so edges of either sense only take effect with clock low
   wire paused = sclk ? pause_r : ~hold_n;

   assign miso = out_sh_r[7];
   assign miso_oe_n = ~(drive_r && !cs_n && !paused);

   // ==========================================================
   // system domain: synchronisers
   logic cs_s2_r;
   logic cs_s3_r;
   logic sup_s2_r;
   logic wp_s2_r;
   logic [`EV_NUM-1:0] ev_s2_r;
   logic [`EV_NUM-1:0] ev_s3_r;

   two_flop_sync #(
      .W(1),
      .INIT(1'b1)
   ) i_cs_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .async_in(cs_n),
      .sync_out(cs_s2_r)
   );

   two_flop_sync #(
      .W(1),
      .INIT(1'b0)
   ) i_sup_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .async_in(supply_ok),
      .sync_out(sup_s2_r)
   );

   two_flop_sync #(
      .W(1),
      .INIT(1'b0)
   ) i_wp_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .async_in(wp_n),
      .sync_out(wp_s2_r)
   );

   // toggles change one bit per event, so bitwise crossing is safe
   two_flop_sync #(
      .W(`EV_NUM),
      .INIT({`EV_NUM{1'b0}})
   ) i_ev_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .async_in(ev_tgl_r),
      .sync_out(ev_s2_r)
   );

   // third stage of select and events, used for edge detection only
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cs_s3_r <= 1'b1;
         ev_s3_r <= '0;
      end else if (clk_en) begin
         cs_s3_r <= cs_s2_r;
         ev_s3_r <= ev_s2_r;
      end
   end

   // ==========================================================
   // system domain: status register and write cycle
   spi_eeprom_pkg::status_ctl_t ctl_r;
   spi_eeprom_pkg::status_ctl_t ctl_nxt;
   logic [`SPI_WC_CNT_W-1:0] wc_cnt_r;
   logic wc_busy_r;
   logic pend_r;
   logic [7:0] status_byte_nxt;

   wire dev_on = sup_s2_r;
   // one-cycle pulse per event, seen past the second stage
   wire [`EV_NUM-1:0] ev = ev_s2_r ^ ev_s3_r;
   // deselect edge, which commits a status write at a byte boundary
   wire cs_rise = cs_s2_r && !cs_s3_r;
   // busy covers our own status write and the array-write logic outside
   wire busy = wc_busy_r || ext_write_busy;
   wire wc_done = wc_busy_r && (wc_cnt_r == '0);
   wire guard_block = ctl_r.guard && !wp_s2_r;
   // a status write commits only on the deselect after a whole data byte
   wire status_write_cmd_seen = pend_r || ev[`EV_STATUS_WRITE_CMD];
   wire status_write_cmd_allowed = ctl_r.latch && !busy && !guard_block;
   wire commit = dev_on && status_write_cmd_seen && cs_rise && !ev[`EV_ABORT] && status_write_cmd_allowed;

   always_comb begin
      ctl_nxt = ctl_r;
      if (commit) begin
         ctl_nxt.guard = status_write_cmd_data_r[`SR_GUARD_BIT];
         ctl_nxt.block = status_write_cmd_data_r[`SR_BLOCK_HI:`SR_BLOCK_LO];
      end
      if (!dev_on) begin
         ctl_nxt.latch = 1'b0;
      end else if (ev[`EV_SET]) begin
         ctl_nxt.latch = 1'b1;
      end else if (ev[`EV_CLEAR] || wc_done || ext_write_done) begin
         ctl_nxt.latch = 1'b0;
      end
   end

   always_comb begin
      status_byte_nxt = 8'h00;
      status_byte_nxt[`SR_GUARD_BIT] = ctl_r.guard;
      status_byte_nxt[`SR_RSV_HI:`SR_RSV_LO] = `SR_RSV_VALUE;
      status_byte_nxt[`SR_BLOCK_HI:`SR_BLOCK_LO] = ctl_r.block;
      status_byte_nxt[`SR_LATCH_BIT] = ctl_r.latch;
      status_byte_nxt[`SR_BUSY_BIT] = busy;
   end

   // status fields and the registered byte handed to the link side
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ctl_r.guard <= `SR_GUARD_RST;
         ctl_r.block <= `SR_BLOCK_RST;
         ctl_r.latch <= 1'b0;
         status_byte_r <= 8'h00;
      end else if (clk_en) begin
         ctl_r <= ctl_nxt;
         status_byte_r <= status_byte_nxt;
      end
   end

   // self-timed write cycle; a pause on the link never reaches it
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         wc_cnt_r <= '0;
         wc_busy_r <= 1'b0;
      end else if (clk_en) begin
         if (!dev_on) begin
            wc_busy_r <= 1'b0;
            wc_cnt_r <= '0;
         end else if (commit) begin
            wc_busy_r <= 1'b1;
            wc_cnt_r <= WC_LOAD;
         end else if (wc_done) begin
            wc_busy_r <= 1'b0;
         end else if (wc_busy_r) begin
            wc_cnt_r <= wc_cnt_r - 1'b1;
         end
      end
   end

   // remembers a finished data byte until its deselect edge arrives
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pend_r <= 1'b0;
      end else if (clk_en) begin
         if (ev[`EV_STATUS_WRITE_CMD] && dev_on) begin
            pend_r <= !cs_rise;
         end else if (ev[`EV_ABORT] || cs_rise || !dev_on) begin
            pend_r <= 1'b0;
         end
      end
   end

   // standby: deselected and no write cycle running
   assign standby = cs_s2_r && !busy;

endmodule

// ==========================================================
// two flip-flop synchroniser for levels from another domain;
// only the second stage is visible outside
module two_flop_sync #(
   parameter int unsigned W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   logic [W-1:0] meta_r;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         meta_r <= INIT;
         sync_out <= INIT;
      end else if (clk_en) begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end

endmodule

// *** hw/spi_eeprom_cfg.svh ***
// constants of the serial eeprom command front end
`ifndef SPI_EEPROM_CFG_SVH
`define SPI_EEPROM_CFG_SVH

// ==========================================================
// instruction codes
`define OP_SET_LATCH 8'h06
`define OP_CLEAR_LATCH 8'h04
`define OP_STATUS_READ 8'h05
`define OP_STATUS_WRITE 8'h01
`define OP_ARRAY_READ 8'h03
`define OP_ARRAY_WRITE 8'h02
`define OP_IDENT_READ 8'h83
`define OP_IDENT_WRITE 8'h82
`define OP_UNIQUE_READ 8'h81

// ==========================================================
// status byte layout and reset values
`define SR_GUARD_BIT 7
`define SR_RSV_HI 6
`define SR_RSV_LO 4
`define SR_BLOCK_HI 3
`define SR_BLOCK_LO 2
`define SR_LATCH_BIT 1
`define SR_BUSY_BIT 0
`define SR_RSV_VALUE 3'h0
`define SR_GUARD_RST 1'h0
`define SR_BLOCK_RST 2'h0

// ==========================================================
// link events carried by toggles
`define EV_SET 0
`define EV_CLEAR 1
`define EV_STATUS_WRITE_CMD 2
`define EV_ABORT 3
`define EV_NUM 4

// ==========================================================
// timing
`define SPI_SYS_CLK_MHZ 250
`define SPI_WRITE_CYCLE_US 1000
`define SPI_WRITE_CYCLE_CYCLES (`SPI_WRITE_CYCLE_US * `SPI_SYS_CLK_MHZ)
`define SPI_WC_CNT_W 20

`endif

// *** hw/spi_eeprom_pkg.sv ***
// types of the serial eeprom command front end
package spi_eeprom_pkg;

   typedef enum logic [2:0] {
      LS_CMD = 3'h0,
      LS_STATUS = 3'h1,
      LS_STATUS_WRITE_CMD = 3'h2,
      LS_STATUS_WRITE_CMD_DONE = 3'h3,
      LS_WAIT = 3'h4,
      LS_HANDOFF = 3'h5
   } link_state_t;

   typedef struct packed {
      logic guard;
      logic [1:0] block;
      logic latch;
   } status_ctl_t;

endpackage

// *** test/spi_eeprom_checker.sv ***
// port assertions for the eeprom command front end
`timescale 1ns/100ps
module spi_eeprom_checker (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic supply_ok,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic hold_n,
   input wire logic ext_write_busy,
   input wire logic ext_write_done,
   input wire logic miso_oe_n,
   input wire logic [7:0] status_byte_r,
   input wire logic standby
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   // ==========================================================
   // properties
   sequence s_done;
      ext_write_done && clk_en && cs_n && $past(cs_n, 4) ##1 clk_en;
   endsequence
   sequence s_busy;
      (ext_write_busy && clk_en) [*3];
   endsequence
   property p_desel; cs_n |-> miso_oe_n; endproperty
   a_desel: assert property (p_desel) else $error("output on while deselected");
   property p_pause; !hold_n && !sclk && !cs_n |-> miso_oe_n; endproperty
   a_pause: assert property (p_pause) else $error("output on while paused");
   property p_rsv; status_byte_r[6:4] == 3'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits set");
   property p_reset; disable iff (1'b0) !rst_n && clk_en |=> status_byte_r == 8'h00 && standby;
   endproperty
   a_reset: assert property (p_reset) else $error("reset state wrong");
   property p_active; (!cs_n) [*4] |-> !standby; endproperty
   a_active: assert property (p_active) else $error("standby while selected");
   property p_done; s_done |=> !status_byte_r[1]; endproperty
   a_done: assert property (p_done) else $error("latch kept after write end");
   property p_guard; (!cs_n) [*8] |-> $stable(status_byte_r[7:2]); endproperty
   a_guard: assert property (p_guard) else $error("guard bits moved in frame");
   property p_busy; s_busy |-> status_byte_r[0] && !standby; endproperty
   a_busy: assert property (p_busy) else $error("busy flag missing");
   property p_brown; (!supply_ok && clk_en) [*5] |-> !status_byte_r[1]; endproperty
   a_brown: assert property (p_brown) else $error("latch kept at supply loss");
endmodule
bind spi_eeprom_command_front_end spi_eeprom_checker i_chk (.sys_clk(sys_clk), .rst_n(rst_n),
   .clk_en(clk_en), .supply_ok(supply_ok), .sclk(sclk), .cs_n(cs_n), .hold_n(hold_n),
   .ext_write_busy(ext_write_busy), .ext_write_done(ext_write_done), .miso_oe_n(miso_oe_n),
   .status_byte_r(status_byte_r), .standby(standby));

// *** test/spi_master_model.sv ***
// serial master model that drives the eeprom link
`timescale 1ns/100ps
module spi_master_model (
   output logic sclk,
   output logic cs_n,
   output logic mosi,
   output logic hold_n,
   input wire logic miso,
   input wire logic miso_oe_n
);
   logic cpol_r = 1'b0;
   logic heard_r = 1'b0;
   logic hold_oe_r = 1'b1;
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
      hold_n = 1'b1;
   end
   always @(miso_oe_n) if (miso_oe_n === 1'b0) heard_r = 1'b1;
   // ==========================================================
   // frame tasks, clock stands at its idle level between frames
   task automatic start(input logic cpol);
      cpol_r = cpol;
      sclk = cpol;
      heard_r = 1'b0;
      #5 cs_n = 1'b0;
      #16;
   endtask
   task automatic xfer(input logic [7:0] tx, input int nbits, input int hold_at,
                       output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - nbits; i--) begin
         sclk = 1'b0;
         if (i == hold_at) begin
            #8 hold_n = 1'b0;
            repeat (2) begin
               #16 sclk = 1'b1;
               mosi = ~mosi;
               #16 sclk = 1'b0;
               hold_oe_r = hold_oe_r & miso_oe_n;
            end
            #8 hold_n = 1'b1;
         end
         mosi = tx[i];
         #16 sclk = 1'b1;
         rx[i] = miso_oe_n ? 1'bx : miso;
         #16;
      end
   endtask
   task automatic stop();
      #16 sclk = cpol_r;
      #16 cs_n = 1'b1;
      mosi = ~mosi;
      #16;
   endtask
   task automatic cut();
      #16 sclk = 1'b0;
      #8 hold_n = 1'b0;
      #16 cs_n = 1'b1;
      #8 hold_n = 1'b1;
      sclk = cpol_r;
      #32;
   endtask
endmodule

// *** test/spi_eeprom_command_front_end_tb_top.sv ***
// self-checking bench of the eeprom command front end
`timescale 1ns/100ps
module spi_eeprom_command_front_end_tb_top;
   typedef struct packed {logic [7:0] op; logic cpol; logic talks; logic [7:0] sr;} row_t;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic supply_ok = 1'b1;
   logic wp_n = 1'b1;
   logic busy_in = 1'b0;
   logic done_in = 1'b0;
   logic sclk, cs_n, mosi, hold_n, miso, miso_oe_n, standby;
   logic [7:0] status_byte_r, r1, r2;
   int bad_count = 0;
   int check_count = 0;
   int ticks = 0;
   row_t rows [11] = '{'{8'h06, 1'h0, 1'h0, 8'h02}, '{8'h04, 1'h1, 1'h0, 8'h00},
      '{8'h06, 1'h1, 1'h0, 8'h02}, '{8'h03, 1'h0, 1'h0, 8'h02}, '{8'h02, 1'h0, 1'h0, 8'h02},
      '{8'h82, 1'h1, 1'h0, 8'h02}, '{8'h83, 1'h0, 1'h0, 8'h02}, '{8'h81, 1'h1, 1'h0, 8'h02},
      '{8'hA5, 1'h0, 1'h0, 8'h02}, '{8'h05, 1'h1, 1'h1, 8'h02}, '{8'h04, 1'h0, 1'h0, 8'h00}};
   initial forever #2 sys_clk = ~sys_clk;
   spi_eeprom_command_front_end #(.WRITE_CYCLE_CYCLES(200)) i_dut (.sys_clk(sys_clk),
      .rst_n(rst_n), .clk_en(1'b1), .supply_ok(supply_ok), .sclk(sclk), .cs_n(cs_n),
      .mosi(mosi), .hold_n(hold_n), .wp_n(wp_n), .ext_write_busy(busy_in),
      .ext_write_done(done_in), .miso(miso), .miso_oe_n(miso_oe_n),
      .status_byte_r(status_byte_r), .standby(standby));
   spi_master_model i_master (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .hold_n(hold_n),
      .miso(miso), .miso_oe_n(miso_oe_n));
   // ==========================================================
   // helpers
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s exp %h seen %h", name, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic frame(input logic cpol, input logic [7:0] op, input logic [7:0] dat,
                        input int nb, input int hold_at);
      i_master.start(cpol);
      i_master.xfer(op, 8, -1, r1);
      if (nb > 1) i_master.xfer(dat, 8, hold_at, r1);
      if (nb > 2) i_master.xfer(8'h00, 8, -1, r2);
      i_master.stop();
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge sys_clk) begin
      ticks++;
      if (ticks == 30000) begin
         bad_count++;
         wrap_up();
      end
   end
   initial begin
      cyc(3);
      rst_n = 1'b1;
      cyc(10);
      chk("reset status", status_byte_r, 8'h00);
      chk("reset standby", {7'h00, standby}, 8'h01);
      foreach (rows[i]) begin
         frame(rows[i].cpol, rows[i].op, 8'h00, 3, -1);
         chk("talks", {7'h00, i_master.heard_r}, {7'h00, rows[i].talks});
         frame(rows[i].cpol, 8'h05, 8'h00, 3, -1);
         chk("status", r1, rows[i].sr);
         chk("repeat", r2, rows[i].sr);
      end
      frame(1'b0, 8'h06, 8'h00, 1, -1);
      frame(1'b1, 8'h01, 8'hFF, 2, -1);
      frame(1'b0, 8'h05, 8'h00, 2, -1);
      chk("busy read", r1, 8'h8F);
      cyc(250);
      chk("after write", status_byte_r, 8'h8C);
      wp_n = 1'b0;
      frame(1'b0, 8'h06, 8'h00, 1, -1);
      frame(1'b0, 8'h01, 8'h00, 2, -1);
      cyc(10);
      chk("guarded", status_byte_r, 8'h8E);
      wp_n = 1'b1;
      frame(1'b0, 8'h06, 8'h00, 1, -1);
      frame(1'b0, 8'h01, 8'h00, 2, -1);
      cyc(250);
      chk("unguarded", status_byte_r, 8'h00);
      i_master.start(1'b0);
      i_master.xfer(8'h05, 4, -1, r1);
      i_master.cut();
      frame(1'b0, 8'h06, 8'h00, 1, -1);
      frame(1'b1, 8'h05, 8'h00, 3, 4);
      chk("paused read", r1, 8'h02);
      chk("paused oe", {7'h00, i_master.hold_oe_r}, 8'h01);
      cyc(1);
      busy_in = 1'b1;
      cyc(4);
      chk("ext busy", {6'h00, status_byte_r[0], standby}, 8'h02);
      busy_in = 1'b0;
      done_in = 1'b1;
      cyc(1);
      done_in = 1'b0;
      cyc(3);
      chk("write done", status_byte_r, 8'h00);
      frame(1'b0, 8'h06, 8'h00, 1, -1);
      cyc(4);
      supply_ok = 1'b0;
      cyc(6);
      chk("brownout", status_byte_r, 8'h00);
      rst_n = 1'b0;
      cyc(3);
      rst_n = 1'b1;
      supply_ok = 1'b1;
      cyc(4);
      chk("standby", {7'h00, standby}, 8'h01);
      wrap_up();
   end
endmodule
